/* File: shared/stc_consts.svh */
// What this block does
// RQ1 - 16-bit up-counter read and written as two bytes; byte writes replace running count
// RQ2 - run_on 0 stops; run_on 1 gate_enable 0 always counts; both 1 gated
// RQ3 - clock select 00 instruction, 01 system, 10 pin or crystal, 11 reserved
// RQ4 - system clock mode advances four counts per instruction cycle
// RQ5 - external source counts on rising edges, synchronized or asynchronous
// RQ6 - external counting needs a falling edge before first counted rising edge
// RQ7 - prescale select divides count clock by 1, 2, 4 or 8
// RQ8 - prescaler hidden from software, cleared on any count byte write
// RQ9 - crystal enable starts crystal oscillator, which keeps running in sleep
// RQ10 - software waits for overflow from preset before trusting crystal timing
// RQ11 - sync bypass 1 lets external clock count without synchronization
// RQ12 - asynchronous external counting runs in sleep and overflow wakes processor
// RQ13 - switching sync mode may lose or add one count
// RQ14 - rollover from maximum to zero sets sticky overflow flag
// RQ15 - gated counting only while gate level matches gate polarity
// RQ16 - synchronized external clock passes two-stage synchronizer, one pulse per edge
// RQ17 - reserved clock select supplies no count clock, counter holds
`ifndef STC_CONSTS_SVH
`define STC_CONSTS_SVH
`define STC_ADDR_CTRL     12'h000
`define STC_ADDR_GATE     12'h004
`define STC_ADDR_CNT_LO   12'h008
`define STC_ADDR_CNT_HI   12'h00C
`define STC_ADDR_STATUS   12'h010
`define STC_ADDR_MASK     12'h014
`define STC_CTRL_RUN      0
`define STC_CTRL_SYNCBYP  2
`define STC_CTRL_OSCEN    3
`define STC_CTRL_PS_LO    4
`define STC_CTRL_CS_LO    6
`define STC_GATE_EN       7
`define STC_GATE_POL      6
`define STC_CTRL_RESET    8'h00
`define STC_GATE_RESET    8'h00
`define STC_CNT_RESET     16'h0000
`define STC_INSTR_DIV     2'h3
`endif

/* File: shared/stc_pkg.sv */
package stc_pkg;
    typedef enum logic [1:0] {
        STC_CS_INSTR = 2'h0,
        STC_CS_SYS   = 2'h1,
        STC_CS_EXT   = 2'h2,
        STC_CS_RSVD  = 2'h3
    } stc_clksel_e;

    typedef enum logic [1:0] {
        STC_ARM_WAIT_LOW = 2'h0,
        STC_ARM_READY    = 2'h1
    } stc_arm_e;

    typedef struct packed {
        stc_clksel_e clockSelect;
        logic [1:0]  prescaleSelect;
        logic        crystalOscEnable;
        logic        syncBypass;
        logic        unused;
        logic        runOn;
    } stc_ctrl_s;

    typedef struct packed {
        logic       gateEnable;
        logic       gatePolarity;
        logic [5:0] unused;
    } stc_gate_s;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } stc_apb_req_s;
endpackage : stc_pkg

/* File: logic/stc_edge_arm.sv */
`timescale 1ns/1ns
`include "stc_consts.svh"
module stc_edge_arm
    import stc_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic rearm,
    input  wire logic levelIn,
    input  wire logic enable,
    output logic      risePulse
);
    logic     levelQ;
    stc_arm_e armQ;

    always_ff @(posedge clk) begin
        if (reset) begin
            levelQ <= 1'b0;
        end else begin
            levelQ <= levelIn;
        end
    end

    // arming requires a falling edge seen while enabled
    always_ff @(posedge clk) begin
        if (reset || rearm || !enable) begin
            armQ <= STC_ARM_WAIT_LOW; // RQ6
        end else if (levelQ && !levelIn) begin
            armQ <= STC_ARM_READY; // RQ6
        end
    end

    assign risePulse = enable && (armQ == STC_ARM_READY) && !levelQ && levelIn; // RQ5

    // no fall seen while waiting means no counted rise next cycle
    property p_noRiseUnarmed;
        @(posedge clk) disable iff (reset)
        (armQ == STC_ARM_WAIT_LOW && !(levelQ && !levelIn)) |=> !risePulse;
    endproperty
    a_noRiseUnarmed: assert property (p_noRiseUnarmed) // RQ6
        else $error("counted rise before falling edge");
endmodule : stc_edge_arm

/* File: logic/stc_timer.sv */
`timescale 1ns/1ns
`include "stc_consts.svh"
module stc_timer (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic         externalCountPin,
    input  wire logic         crystalInPin,
    output logic              crystalOutPin,
    output logic              crystalOutEn,
    input  wire logic         gatePin,
    input  wire logic         sleepMode,
    output logic              irq,
    output logic              wakeRequest
);
    import stc_pkg::*;

    stc_ctrl_s   ctrlQ;
    stc_gate_s   gateQ;
    logic [15:0] countQ;
    logic [15:0] countD;
    logic [2:0]  prescQ;
    logic        overflowFlagQ;
    logic        overflowMaskQ;
    logic [1:0]  instrDivQ;
    logic        extSrc;
    logic        extSync1Q;
    logic        extSync2Q;
    logic        extLevel;
    logic        extRise;
    logic        runEnable;
    logic        gateOk;
    logic        srcTick;
    logic        prescTick;
    logic        cntWrite;
    logic        wrCycle;
    logic        rdCycle;
    logic        rolls;
    logic        rdStatus;
    logic [2:0]  prescLimit;

    assign wrCycle  = psel && penable && pwrite;
    assign rdCycle  = psel && penable && !pwrite;
    assign cntWrite = wrCycle && (paddr == `STC_ADDR_CNT_LO || paddr == `STC_ADDR_CNT_HI);
    assign rdStatus = rdCycle && (paddr == `STC_ADDR_STATUS);

    // control registers
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrlQ <= stc_ctrl_s'(`STC_CTRL_RESET);
            gateQ <= stc_gate_s'(`STC_GATE_RESET);
            overflowMaskQ <= 1'b0;
        end else if (wrCycle) begin
            if (paddr == `STC_ADDR_CTRL) begin
                ctrlQ <= stc_ctrl_s'(pwdata[7:0] & 8'hFD);
            end else if (paddr == `STC_ADDR_GATE) begin
                gateQ <= stc_gate_s'(pwdata[7:0] & 8'hC0);
            end else if (paddr == `STC_ADDR_MASK) begin
                overflowMaskQ <= pwdata[0];
            end
        end
    end

    // crystal driver, free running in sleep when enabled
    always_ff @(posedge clk) begin
        if (reset) begin
            crystalOutPin <= 1'b0;
            crystalOutEn  <= 1'b0;
        end else begin
            crystalOutEn  <= ctrlQ.crystalOscEnable; // RQ9
            crystalOutPin <= ctrlQ.crystalOscEnable && !crystalInPin; // RQ9
        end
    end

    assign extSrc = ctrlQ.crystalOscEnable ? crystalInPin : externalCountPin; // RQ3

    // two-stage synchronizer for external source
    always_ff @(posedge clk) begin
        if (reset) begin
            extSync1Q <= 1'b0;
            extSync2Q <= 1'b0;
        end else begin
            extSync1Q <= extSrc; // RQ16
            extSync2Q <= extSync1Q; // RQ16
        end
    end

    // bypass takes the raw pin level; sync path adds two cycles
    assign extLevel = ctrlQ.syncBypass ? extSrc : extSync2Q; // RQ11 RQ13

    assign gateOk    = (gatePin == gateQ.gatePolarity); // RQ15
    assign runEnable = ctrlQ.runOn && (!gateQ.gateEnable || gateOk); // RQ2

    stc_edge_arm i_stc_edge_arm (
        .clk       (clk),
        .reset     (reset),
        .rearm     (cntWrite),
        .levelIn   (extLevel),
        .enable    (ctrlQ.runOn && ctrlQ.clockSelect == STC_CS_EXT),
        .risePulse (extRise)
    );

    // instruction clock is one enable in four system cycles
    always_ff @(posedge clk) begin
        if (reset) begin
            instrDivQ <= 2'h0;
        end else begin
            instrDivQ <= instrDivQ + 2'h1;
        end
    end

    always_comb begin
        case (ctrlQ.clockSelect)
            STC_CS_INSTR: srcTick = (instrDivQ == `STC_INSTR_DIV); // RQ3
            STC_CS_SYS:   srcTick = 1'b1; // RQ4
            STC_CS_EXT:   srcTick = extRise; // RQ5
            default:      srcTick = 1'b0; // RQ17
        endcase
    end

    always_comb begin
        case (ctrlQ.prescaleSelect)
            2'h0:    prescLimit = 3'h0;
            2'h1:    prescLimit = 3'h1;
            2'h2:    prescLimit = 3'h3;
            default: prescLimit = 3'h7;
        endcase
    end

    // hidden prescaler
    always_ff @(posedge clk) begin
        if (reset || cntWrite) begin
            prescQ <= 3'h0; // RQ8
        end else if (srcTick && runEnable) begin
            prescQ <= (prescQ >= prescLimit) ? 3'h0 : prescQ + 3'h1; // RQ7
        end
    end

    assign prescTick = srcTick && runEnable && (prescQ >= prescLimit); // RQ7
    assign rolls     = prescTick && (countQ == 16'hFFFF);

    always_comb begin
        countD = countQ;
        if (prescTick) begin
            countD = countQ + 16'h0001; // RQ1
        end
        if (wrCycle && paddr == `STC_ADDR_CNT_LO) begin
            countD = {countQ[15:8], pwdata[7:0]}; // RQ1
        end else if (wrCycle && paddr == `STC_ADDR_CNT_HI) begin
            countD = {pwdata[7:0], countQ[7:0]}; // RQ1
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            countQ <= `STC_CNT_RESET;
        end else begin
            countQ <= countD;
        end
    end

    // sticky flag, set wins over read-clear
    always_ff @(posedge clk) begin
        if (reset) begin
            overflowFlagQ <= 1'b0;
        end else if (rolls) begin
            overflowFlagQ <= 1'b1; // RQ14
        end else if (rdStatus) begin
            overflowFlagQ <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irq         <= 1'b0;
            wakeRequest <= 1'b0;
        end else begin
            irq         <= (overflowFlagQ || rolls) && overflowMaskQ && !(rdStatus && !rolls);
            wakeRequest <= sleepMode && rolls && ctrlQ.syncBypass
                           && ctrlQ.clockSelect == STC_CS_EXT; // RQ12
        end
    end

    // apb slave, single access cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                if (paddr == `STC_ADDR_CTRL) begin
                    prdata <= {24'h000000, ctrlQ};
                end else if (paddr == `STC_ADDR_GATE) begin
                    prdata <= {24'h000000, gateQ};
                end else if (paddr == `STC_ADDR_CNT_LO) begin
                    prdata <= {24'h000000, countQ[7:0]};
                end else if (paddr == `STC_ADDR_CNT_HI) begin
                    prdata <= {24'h000000, countQ[15:8]};
                end else if (paddr == `STC_ADDR_STATUS) begin
                    prdata <= {31'h0, overflowFlagQ};
                end else if (paddr == `STC_ADDR_MASK) begin
                    prdata <= {31'h0, overflowMaskQ};
                end else begin
                    pslverr <= 1'b1;
                end
            end else if (psel && !penable) begin
                pslverr <= !(paddr == `STC_ADDR_CTRL || paddr == `STC_ADDR_GATE || paddr == `STC_ADDR_CNT_LO
                             || paddr == `STC_ADDR_CNT_HI || paddr == `STC_ADDR_STATUS
                             || paddr == `STC_ADDR_MASK);
            end
        end
    end

    property p_rollSetsFlag;
        @(posedge clk) disable iff (reset)
        rolls |=> overflowFlagQ;
    endproperty
    a_rollSetsFlag: assert property (p_rollSetsFlag) // RQ14
        else $error("rollover did not set flag");

    property p_offHolds;
        @(posedge clk) disable iff (reset)
        (!ctrlQ.runOn && !wrCycle) |=> (countQ == $past(countQ)); // RQ2
    endproperty
    a_offHolds: assert property (p_offHolds) // RQ2
        else $error("count moved while off");

    property p_reservedHolds;
        @(posedge clk) disable iff (reset)
        (ctrlQ.clockSelect == STC_CS_RSVD && !wrCycle) |=> (countQ == $past(countQ));
    endproperty
    a_reservedHolds: assert property (p_reservedHolds) // RQ17
        else $error("count moved on reserved select");

    property p_gateHolds;
        @(posedge clk) disable iff (reset)
        (gateQ.gateEnable && !gateOk && !wrCycle) |=> (countQ == $past(countQ));
    endproperty
    a_gateHolds: assert property (p_gateHolds) // RQ15
        else $error("count moved with gate closed");

    property p_writeClearsPresc;
        @(posedge clk) disable iff (reset)
        cntWrite |=> (prescQ == 3'h0);
    endproperty
    a_writeClearsPresc: assert property (p_writeClearsPresc) // RQ8
        else $error("prescaler not cleared by count write");

    property p_writeLo;
        @(posedge clk) disable iff (reset)
        (wrCycle && paddr == `STC_ADDR_CNT_LO) |=> (countQ[7:0] == $past(pwdata[7:0]));
    endproperty
    a_writeLo: assert property (p_writeLo) // RQ1
        else $error("low byte write lost");

    property p_writeHi;
        @(posedge clk) disable iff (reset)
        (wrCycle && paddr == `STC_ADDR_CNT_HI) |=> (countQ[15:8] == $past(pwdata[7:0]));
    endproperty
    a_writeHi: assert property (p_writeHi) // RQ1
        else $error("high byte write lost");

    property p_sysFree;
        @(posedge clk) disable iff (reset)
        (ctrlQ.clockSelect == STC_CS_SYS && ctrlQ.prescaleSelect == 2'h0 && runEnable && !wrCycle)
            |=> (countQ == $past(countQ) + 16'h0001);
    endproperty
    a_sysFree: assert property (p_sysFree) // RQ4
        else $error("system clock count not every cycle");

    property p_prescStep;
        @(posedge clk) disable iff (reset)
        prescTick |-> (prescQ == prescLimit);
    endproperty
    a_prescStep: assert property (p_prescStep) // RQ7
        else $error("prescaler tick at wrong count");
endmodule : stc_timer

/* File: testbench/stc_ext_src.sv */
`timescale 1ns/1ns
module stc_ext_src (
    input  wire logic clk,
    output logic      countPin,
    output logic      xtalPin
);
    // both sources rest low between frames
    initial begin
        countPin = 1'b0;
        xtalPin = 1'b0;
    end

    // leading rise is not armed, so n of the n+1 rises count
    task frame(input logic useXtal, input int n, input int half);
        for (int i = 0; i <= n; i++) begin
            repeat (half) @(posedge clk);
            if (useXtal) xtalPin <= 1'b1;
            else countPin <= 1'b1;
            repeat (half) @(posedge clk);
            if (useXtal) xtalPin <= 1'b0;
            else countPin <= 1'b0;
        end
    endtask : frame
endmodule : stc_ext_src

/* File: testbench/stc_timer_tb.sv */
`timescale 1ns/1ns
`include "stc_consts.svh"
module stc_timer_tb;
    import stc_pkg::*;
    logic        clk, reset, psel, penable, pwrite, gatePin, sleepMode, errSeen;
    logic        pready, pslverr, crystalOutPin, crystalOutEn, irq, wakeRequest, wakeSeen, extPin, xtalPin;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] cnt;
    int          failures, checks_done;
    logic [1:0]  csT [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h3};
    logic [1:0]  psT [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
    int          expT [6] = '{100, 50, 25, 12, 400, 0};

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    stc_timer i_stc_timer (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .externalCountPin(extPin), .crystalInPin(xtalPin), .crystalOutPin(crystalOutPin),
        .crystalOutEn(crystalOutEn), .gatePin(gatePin), .sleepMode(sleepMode), .irq(irq),
        .wakeRequest(wakeRequest));
    stc_ext_src i_stc_ext_src (.clk(clk), .countPin(extPin), .xtalPin(xtalPin));

    always @(posedge clk) if (wakeRequest === 1'b1) wakeSeen <= 1'b1;

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task readCnt;
        apb(1'b0, `STC_ADDR_CNT_HI, 32'h0);
        cnt[15:8] = rd[7:0];
        apb(1'b0, `STC_ADDR_CNT_LO, 32'h0);
        cnt[7:0] = rd[7:0];
    endtask : readCnt

    task setCnt(input logic [15:0] v);
        apb(1'b1, `STC_ADDR_CNT_HI, {24'h0, v[15:8]});
        apb(1'b1, `STC_ADDR_CNT_LO, {24'h0, v[7:0]});
    endtask : setCnt

    task setCtrl(input logic [1:0] cs, input logic [1:0] ps, input logic osc, input logic syn);
        apb(1'b1, `STC_ADDR_CTRL, {24'h0, cs, ps, osc, syn, 2'h1});
    endtask : setCtrl

    task summarize;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        summarize();
    end

    initial begin
        reset = 1'b1;
        {psel, penable, pwrite, gatePin, sleepMode, wakeSeen} = 6'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        failures = 0;
        checks_done = 0;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        for (int a = 0; a <= 20; a += 4) begin
            apb(1'b0, a[11:0], 32'h0);
            chk(rd, 32'h0);
        end
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, errSeen}, 32'h1);
        chk(rd, 32'h0);
        setCnt(16'h1234);
        apb(1'b1, `STC_ADDR_CTRL, 32'h40);
        repeat (50) @(posedge clk);
        readCnt();
        chk(cnt, 16'h1234);
        apb(1'b1, `STC_ADDR_GATE, 32'hC0);
        for (int i = 0; i < 6; i++) begin
            setCtrl(csT[i], psT[i], 1'b0, 1'b0);
            setCnt(16'h0000);
            repeat (40) @(posedge clk);
            readCnt();
            chk(cnt, 16'h0000);
            gatePin <= 1'b1;
            repeat (400) @(posedge clk);
            gatePin <= 1'b0;
            repeat (4) @(posedge clk);
            readCnt();
            chk(cnt + 16'h0001 >= 16'(expT[i]) && cnt <= 16'(expT[i] + 1), 1);
        end
        apb(1'b1, `STC_ADDR_GATE, 32'h0);
        setCtrl(2'h2, 2'h0, 1'b0, 1'b0);
        setCnt(16'h0000);
        i_stc_ext_src.frame(1'b0, 10, 3);
        repeat (6) @(posedge clk);
        readCnt();
        chk(cnt, 16'h000A);
        setCtrl(2'h2, 2'h0, 1'b1, 1'b1);
        apb(1'b0, `STC_ADDR_STATUS, 32'h0);
        chk(crystalOutEn, 1'b1);
        setCnt(16'hFC00);
        sleepMode <= 1'b1;
        i_stc_ext_src.frame(1'b1, 1024, 2);
        repeat (4) @(posedge clk);
        chk(irq, 1'b0);
        chk(wakeSeen, 1'b1);
        chk(crystalOutPin, 1'b1);
        apb(1'b1, `STC_ADDR_MASK, 32'h1);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        apb(1'b0, `STC_ADDR_STATUS, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, `STC_ADDR_STATUS, 32'h0);
        chk(rd, 32'h0);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        sleepMode <= 1'b0;
        readCnt();
        chk(cnt <= 16'h0001 || cnt == 16'hFFFF, 1);
        summarize();
    end
endmodule : stc_timer_tb
